//--- hw/drrm_defs.svh
`ifndef DRRM_DEFS_SVH
`define DRRM_DEFS_SVH
// ==========================================================
// Mode register selectors and field positions
`define DRRM_MR_THERMAL 3'h4
`define DRRM_MR_FEATURE 3'h3
`define DRRM_TCR_EN_BIT 3
`define DRRM_TCR_EXT_BIT 2
`define DRRM_FGR_HI 8
`define DRRM_FGR_LO 6
// ==========================================================
// Granularity codes
`define DRRM_FGR_FIX1 3'h0
`define DRRM_FGR_FIX2 3'h1
`define DRRM_FGR_FIX4 3'h2
`define DRRM_FGR_OTF12 3'h5
`define DRRM_FGR_OTF14 3'h6
// ==========================================================
// Timing in ns and cycles at 20 ns
`define DRRM_CLK_NS 20
`define DRRM_BASE_REFI_NS 7800
`define DRRM_EXT_REFI_NS 3900
`define DRRM_RFC1_NS 260
`define DRRM_RFC2_NS 160
`define DRRM_RFC4_NS 110
`define DRRM_REFI_CYC(ns) (((ns) / `DRRM_CLK_NS))
`define DRRM_RFC_CYC(ns) (((ns) + `DRRM_CLK_NS - 1) / `DRRM_CLK_NS)
// ==========================================================
// Temperature thresholds in deg C and skip ceilings
`define DRRM_TEMP_COLD 8'sh2D
`define DRRM_TEMP_NORM 8'sh55
`define DRRM_TEMP_HOT 8'sh5F
`define DRRM_SKIP_NORM 2'h3
`define DRRM_SKIP_EXT 3'h7
`endif

//--- hw/drrm_pkg.sv
package drrm_pkg;
  typedef enum logic [1:0] {
    DRRM_RATE_1X = 2'b00,
    DRRM_RATE_2X = 2'b01,
    DRRM_RATE_4X = 2'b10
  } drrm_rate_e;
endpackage

//--- hw/drrm_if.sv
`timescale 1ns/1ps
// ==========================================================
// Command link between controller and device
interface drrm_if;
  logic cs_n;
  logic act_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bg;
  logic [2:0] mr_sel;
  logic [13:0] addr;
  modport ctrl (output cs_n, act_n, ras_n, cas_n, we_n, bg, mr_sel, addr);
  modport dev (input cs_n, act_n, ras_n, cas_n, we_n, bg, mr_sel, addr);
endinterface

//--- hw/drrm_device.sv
`timescale 1ns/1ps
`include "drrm_defs.svh"
module drrm_device import drrm_pkg::*; (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic CLK_EN_I,
  input wire logic signed [7:0] CASE_TEMP_I,
  drrm_if.dev cmd,
  output logic TCR_EN_O,
  output logic TCR_EXT_O,
  output logic [2:0] FGR_MODE_O,
  output logic REFRESH_DO_O,
  output logic REFRESH_SKIP_O,
  output logic [1:0] REFRESH_RATE_O,
  output logic REFRESH_BUSY_O
);
  // ==========================================================
  // Command decode
  wire sel_w = !cmd.cs_n;
  wire is_ref_w = sel_w && cmd.act_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
  wire is_mrs_w = sel_w && cmd.act_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
  wire wr_thermal_w = is_mrs_w && (cmd.mr_sel == `DRRM_MR_THERMAL);
  wire wr_feature_w = is_mrs_w && (cmd.mr_sel == `DRRM_MR_FEATURE);

  logic tcr_en_q, tcr_ext_q;
  logic [2:0] fgr_q;
  logic [2:0] skip_cnt_q;
  logic [3:0] busy_cnt_q;

  // Rate of this refresh from mode and bank-group bit
  // Only the two legal pair codes read bank-group bit zero; reserved codes act as 1x
  wire otf_w = (fgr_q == `DRRM_FGR_OTF12) || (fgr_q == `DRRM_FGR_OTF14);
  drrm_rate_e rate_w;
  assign rate_w = otf_w ? (cmd.bg[0] ? (fgr_q[1] ? DRRM_RATE_4X : DRRM_RATE_2X)
                                      : DRRM_RATE_1X)
                        : (fgr_q == `DRRM_FGR_FIX2 ? DRRM_RATE_2X :
                           fgr_q == `DRRM_FGR_FIX4 ? DRRM_RATE_4X : DRRM_RATE_1X);

  // Busy length per refresh type
  wire [3:0] rfc_w = (rate_w == DRRM_RATE_4X) ? 4'(`DRRM_RFC_CYC(`DRRM_RFC4_NS)) :
                     (rate_w == DRRM_RATE_2X) ? 4'(`DRRM_RFC_CYC(`DRRM_RFC2_NS)) :
                     4'(`DRRM_RFC_CYC(`DRRM_RFC1_NS));

  // Skip ratio from temperature; never beyond the ceiling of each range
  wire cold_w = CASE_TEMP_I < `DRRM_TEMP_COLD;
  wire in_norm_w = CASE_TEMP_I <= `DRRM_TEMP_NORM;
  wire [2:0] skip_lim_w =
      !tcr_en_q ? 3'h0 :
      !tcr_ext_q ? (cold_w ? 3'(`DRRM_SKIP_NORM) : 3'h0) :
      cold_w ? `DRRM_SKIP_EXT : (in_norm_w ? 3'h1 : 3'h0);
  wire skip_w = skip_cnt_q < skip_lim_w;
  wire [2:0] skip_nxt_w = skip_w ? skip_cnt_q + 3'h1 : 3'h0;

  // ==========================================================
  // Mode registers, reset to fixed 1x without TEMP_CONTROLLED_REFRESH
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tcr_en_q <= 1'b0;
      tcr_ext_q <= 1'b0;
      fgr_q <= `DRRM_FGR_FIX1;
    end else if (CLK_EN_I) begin
      if (wr_thermal_w) begin
        tcr_en_q <= cmd.addr[`DRRM_TCR_EN_BIT];
        tcr_ext_q <= cmd.addr[`DRRM_TCR_EXT_BIT];
      end
      if (wr_feature_w) fgr_q <= cmd.addr[`DRRM_FGR_HI:`DRRM_FGR_LO];
    end
  end

  // ==========================================================
  // Refresh execution and skip gearing
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      skip_cnt_q <= 3'h0;
      busy_cnt_q <= 4'h0;
      REFRESH_DO_O <= 1'b0;
      REFRESH_SKIP_O <= 1'b0;
      REFRESH_RATE_O <= 2'h0;
    end else if (CLK_EN_I) begin
      REFRESH_DO_O <= is_ref_w && !skip_w;
      REFRESH_SKIP_O <= is_ref_w && skip_w;
      if (is_ref_w) begin
        skip_cnt_q <= skip_nxt_w;
        REFRESH_RATE_O <= rate_w;
        busy_cnt_q <= rfc_w;
      end else if (busy_cnt_q != 4'h0) begin
        busy_cnt_q <= busy_cnt_q - 4'h1;
      end
    end
  end

  // Status outputs mirror the mode registers one stage late; busy flag from refresh and counter
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      TCR_EN_O <= 1'b0;
      TCR_EXT_O <= 1'b0;
      FGR_MODE_O <= `DRRM_FGR_FIX1;
      REFRESH_BUSY_O <= 1'b0;
    end else if (CLK_EN_I) begin
      TCR_EN_O <= tcr_en_q;
      TCR_EXT_O <= tcr_ext_q;
      FGR_MODE_O <= fgr_q;
      REFRESH_BUSY_O <= is_ref_w || (busy_cnt_q > 4'h1);
    end
  end
endmodule // drrm_device

//--- hw/drrm_ctrl.sv
`timescale 1ns/1ps
`include "drrm_defs.svh"
// ==========================================================
// Controller end: programs modes and issues timed refreshes
module drrm_ctrl import drrm_pkg::*; (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic CLK_EN_I,
  input wire logic CFG_REQ_I,
  input wire logic CFG_TCR_EN_I,
  input wire logic CFG_TCR_EXT_I,
  input wire logic [2:0] CFG_FGR_I,
  input wire logic CFG_WIDE_HOT_I,
  input wire logic HIGH_RATE_I,
  input wire logic signed [7:0] CASE_TEMP_I,
  drrm_if.ctrl cmd,
  output logic CFG_DONE_O,
  output logic REF_ISSUED_O
);
  typedef enum logic [1:0] {
    DRRM_ST_IDLE = 2'b00,
    DRRM_ST_THERM = 2'b01,
    DRRM_ST_FEAT = 2'b10,
    DRRM_ST_RUN = 2'b11
  } drrm_st_e;

  drrm_st_e st_q;
  logic [2:0] fgr_q;
  logic tcr_en_q, tcr_ext_q, dbl_odd_q;
  logic [3:0] quad_cnt_q;
  logic [8:0] refi_q, rfc_q;

  // ==========================================================
  // Thermal refresh forces fixed 1x granularity
  wire [2:0] fgr_req_w = CFG_TCR_EN_I ? `DRRM_FGR_FIX1 : CFG_FGR_I;
  // Pick refresh type; single rate only on group boundary
  wire pair_w = (fgr_q == `DRRM_FGR_OTF12) && dbl_odd_q;
  wire grp_w = (fgr_q == `DRRM_FGR_OTF14) && (quad_cnt_q[1:0] != 2'h0);
  // Reserved codes never ask for a high rate
  wire otf_w = (fgr_q == `DRRM_FGR_OTF12) || (fgr_q == `DRRM_FGR_OTF14);
  wire hi_w = otf_w && (HIGH_RATE_I || pair_w || grp_w);
  drrm_rate_e rate_w;
  assign rate_w = otf_w ? (hi_w ? (fgr_q[1] ? DRRM_RATE_4X : DRRM_RATE_2X)
                                   : DRRM_RATE_1X)
                           : (fgr_q == `DRRM_FGR_FIX2 ? DRRM_RATE_2X :
                              fgr_q == `DRRM_FGR_FIX4 ? DRRM_RATE_4X : DRRM_RATE_1X);
  // Interval: base or extended, scaled by rate and temperature
  wire [8:0] base_w = (tcr_ext_q && !(tcr_en_q == 1'b0 && CASE_TEMP_I < `DRRM_TEMP_NORM))
      ? 9'(`DRRM_REFI_CYC(`DRRM_EXT_REFI_NS))
      : 9'(`DRRM_REFI_CYC(`DRRM_BASE_REFI_NS));
  // Above 95C with CFG_WIDE_HOT_I the extended base is already halved, so only one more step
  wire [1:0] hot_sh_w = (CASE_TEMP_I > `DRRM_TEMP_HOT && CFG_WIDE_HOT_I) ?
                        (tcr_ext_q ? 2'h1 : 2'h2) :
                        (CASE_TEMP_I > `DRRM_TEMP_NORM && !tcr_ext_q) ? 2'h1 : 2'h0;
  wire [8:0] refi_w = (base_w >> rate_w) >> hot_sh_w;
  wire [8:0] rfc_w = (rate_w == DRRM_RATE_4X) ? 9'(`DRRM_RFC_CYC(`DRRM_RFC4_NS)) :
                     (rate_w == DRRM_RATE_2X) ? 9'(`DRRM_RFC_CYC(`DRRM_RFC2_NS)) :
                     9'(`DRRM_RFC_CYC(`DRRM_RFC1_NS));
  // Wait both the interval and the prior cycle time; interval dominates anyway
  wire fire_w = (st_q == DRRM_ST_RUN) && (refi_q == 9'h0) && (rfc_q == 9'h0);
  wire mrs_w = (st_q == DRRM_ST_THERM) || (st_q == DRRM_ST_FEAT);

  // ==========================================================
  // Command pins
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cmd.cs_n <= 1'b1;
      cmd.act_n <= 1'b1;
      cmd.ras_n <= 1'b1;
      cmd.cas_n <= 1'b1;
      cmd.we_n <= 1'b1;
      cmd.bg <= 2'h0;
      cmd.mr_sel <= 3'h0;
      cmd.addr <= 14'h0000;
    end else if (CLK_EN_I) begin
      cmd.cs_n <= !(mrs_w || fire_w);
      cmd.act_n <= 1'b1;
      cmd.ras_n <= !(mrs_w || fire_w);
      cmd.cas_n <= !(mrs_w || fire_w);
      cmd.we_n <= !mrs_w;
      cmd.bg <= {1'b0, fire_w && rate_w != DRRM_RATE_1X && otf_w};
      cmd.mr_sel <= (st_q == DRRM_ST_THERM) ? `DRRM_MR_THERMAL : `DRRM_MR_FEATURE;
      cmd.addr <= (st_q == DRRM_ST_THERM)
          ? 14'({tcr_en_q, tcr_ext_q} << `DRRM_TCR_EXT_BIT)
          : 14'({fgr_q} << `DRRM_FGR_LO);
    end
  end

  // ==========================================================
  // Sequencer: MRS first, then periodic refresh
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_q <= DRRM_ST_IDLE;
      fgr_q <= `DRRM_FGR_FIX1;
      tcr_en_q <= 1'b0;
      tcr_ext_q <= 1'b0;
      dbl_odd_q <= 1'b0;
      quad_cnt_q <= 4'h0;
      refi_q <= 9'h0;
      rfc_q <= 9'h0;
      CFG_DONE_O <= 1'b0;
      REF_ISSUED_O <= 1'b0;
    end else if (CLK_EN_I) begin
      CFG_DONE_O <= (st_q == DRRM_ST_FEAT);
      REF_ISSUED_O <= fire_w;
      if (refi_q != 9'h0) refi_q <= refi_q - 9'h1;
      if (rfc_q != 9'h0) rfc_q <= rfc_q - 9'h1;
      unique case (st_q)
        DRRM_ST_IDLE, DRRM_ST_RUN: begin
          // Mode change only on a completed refresh group
          if (CFG_REQ_I && !dbl_odd_q && quad_cnt_q[1:0] == 2'h0 && rfc_q == 9'h0) begin
            tcr_en_q <= CFG_TCR_EN_I;
            tcr_ext_q <= CFG_TCR_EXT_I;
            fgr_q <= fgr_req_w;
            st_q <= DRRM_ST_THERM;
          end else if (fire_w) begin
            refi_q <= refi_w;
            rfc_q <= rfc_w;
            if (rate_w == DRRM_RATE_2X) dbl_odd_q <= !dbl_odd_q;
            if (rate_w == DRRM_RATE_4X) quad_cnt_q <= quad_cnt_q + 4'h1;
          end
        end
        DRRM_ST_THERM: st_q <= DRRM_ST_FEAT;
        DRRM_ST_FEAT: st_q <= DRRM_ST_RUN;
      endcase
    end
  end
endmodule // drrm_ctrl

//--- verif/drrm_properties.sv
`timescale 1ns/1ps
`include "drrm_defs.svh"
// ==========================================================
// Link and device watcher
module drrm_properties import drrm_pkg::*; (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [2:0] mr_sel,
  input wire logic [13:0] addr,
  input wire logic TCR_EN_O,
  input wire logic TCR_EXT_O,
  input wire logic [2:0] FGR_MODE_O,
  input wire logic REFRESH_DO_O,
  input wire logic REFRESH_SKIP_O,
  input wire logic [1:0] REFRESH_RATE_O,
  input wire logic REFRESH_BUSY_O
);
  logic [2:0] fgr_q;
  logic [3:0] busy_len_q;
  logic [2:0] skip_run_q;
  // Command decode; mode tracked from the pins, not the lagging outputs
  wire ref_cmd = !cs_n && act_n && !ras_n && !cas_n && we_n;
  wire mrs_cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n;
  wire hi = bg[0] && fgr_q[2];
  wire r2 = fgr_q == `DRRM_FGR_FIX2 || (hi && fgr_q == `DRRM_FGR_OTF12);
  wire r4 = fgr_q == `DRRM_FGR_FIX4 || (hi && fgr_q == `DRRM_FGR_OTF14);
  wire [1:0] exp_rate = r4 ? 2'h2 : (r2 ? 2'h1 : 2'h0);
  wire [3:0] rfc_exp = REFRESH_RATE_O == DRRM_RATE_4X ? 4'(`DRRM_RFC_CYC(`DRRM_RFC4_NS)) :
    (REFRESH_RATE_O == DRRM_RATE_2X ? 4'(`DRRM_RFC_CYC(`DRRM_RFC2_NS)) :
    4'(`DRRM_RFC_CYC(`DRRM_RFC1_NS)));
  // Helper counters: busy length and run of skips
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fgr_q <= 3'h0;
      busy_len_q <= 4'h0;
      skip_run_q <= 3'h0;
    end else begin
      if (mrs_cmd && mr_sel == `DRRM_MR_FEATURE) fgr_q <= addr[8:6];
      busy_len_q <= REFRESH_BUSY_O ? busy_len_q + 4'h1 : 4'h0;
      if (REFRESH_SKIP_O) skip_run_q <= skip_run_q + 3'h1;
      else if (REFRESH_DO_O) skip_run_q <= 3'h0;
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // ==========================================================
  // Properties
  ref_answer_a: assert property (ref_cmd |=> REFRESH_DO_O || REFRESH_SKIP_O)
    else $error("refresh got no answer");
  ref_rate_a: assert property (ref_cmd ##1 REFRESH_DO_O |-> REFRESH_RATE_O == $past(exp_rate))
    else $error("refresh rate wrong");
  busy_len_a: assert property ($fell(REFRESH_BUSY_O) |-> busy_len_q == rfc_exp)
    else $error("busy length wrong");
  mrs_order_a: assert property (mrs_cmd && mr_sel == `DRRM_MR_THERMAL |=>
    mrs_cmd && mr_sel == `DRRM_MR_FEATURE)
    else $error("mode writes out of order");
  fgr_load_a: assert property (mrs_cmd && mr_sel == `DRRM_MR_FEATURE |->
    ##2 FGR_MODE_O == $past(addr[8:6], 2))
    else $error("granularity not loaded");
  thermal_load_a: assert property (mrs_cmd && mr_sel == `DRRM_MR_THERMAL |->
    ##2 TCR_EN_O == $past(addr[3], 2) && TCR_EXT_O == $past(addr[2], 2))
    else $error("thermal bits not loaded");
  tcr_fix1_a: assert property (mrs_cmd && mr_sel == `DRRM_MR_THERMAL && addr[3] |=>
    addr[8:6] == 3'h0)
    else $error("granularity not fixed 1x");
  skip_cap_a: assert property (skip_run_q <= (TCR_EXT_O ? 3'h7 : 3'h3))
    else $error("too many skips");
  skip_tcr_a: assert property (REFRESH_SKIP_O |-> TCR_EN_O)
    else $error("skip with thermal mode off");
  ref_gap_a: assert property (ref_cmd |=> !ref_cmd [*8])
    else $error("refreshes too close");
  reset_mode_a: assert property ($fell(RESET_I) |-> FGR_MODE_O == 3'h0 && !TCR_EN_O)
    else $error("mode not default after reset");
endmodule // drrm_properties

//--- verif/tb_dram_refresh_rate_modes.sv
`timescale 1ns/1ps
// ==========================================================
// Both ends joined and walked through every refresh mode
module tb_dram_refresh_rate_modes import drrm_pkg::*;;
  typedef struct {
    logic temp_controlled_refresh, ext, wide, high;
    logic [2:0] fgr;
    logic signed [7:0] temp;
    logic [2:0] xfgr;
    drrm_rate_e rate;
    int gap, skips;
  } drrm_row_s;
  // Rows: tcr ext wide high fgr temp, then mode, rate, gap, skips out of 8
  drrm_row_s rows [14] = '{'{0,0,0,0,0,50,0,DRRM_RATE_1X,390,0},
    '{0,0,0,0,1,50,1,DRRM_RATE_2X,195,0}, '{0,0,0,0,2,50,2,DRRM_RATE_4X,97,0},
    '{0,0,0,1,5,50,5,DRRM_RATE_2X,195,0}, '{0,0,0,0,5,50,5,DRRM_RATE_1X,390,0},
    '{0,0,0,1,6,50,6,DRRM_RATE_4X,97,0}, '{0,0,0,0,3,50,3,DRRM_RATE_1X,390,0},
    '{0,1,0,0,0,60,0,DRRM_RATE_1X,390,0}, '{0,1,0,0,0,90,0,DRRM_RATE_1X,195,0},
    '{0,1,1,0,2,100,2,DRRM_RATE_4X,24,0}, '{1,0,0,0,2,30,0,DRRM_RATE_1X,390,6},
    '{1,1,0,0,0,30,0,DRRM_RATE_1X,195,7}, '{1,1,0,0,0,60,0,DRRM_RATE_1X,195,4},
    '{0,0,0,1,7,50,7,DRRM_RATE_1X,390,0}};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cfg_req = 1'b0, cfg_tcr = 1'b0, cfg_ext = 1'b0, cfg_wide = 1'b0, high_rate = 1'b0;
  logic [2:0] cfg_fgr = 3'h0;
  logic signed [7:0] temp = 8'h32;
  logic tcr_en, tcr_ext, ref_do, ref_skip, ref_busy, cfg_done, ref_issued;
  logic [2:0] fgr_mode;
  logic [1:0] ref_rate;
  int err_total = 0, checks = 0, cyc = 0;
  drrm_if link();
  drrm_ctrl u_drrm_ctrl (.CORE_CLK_I(core_clk), .RESET_I(reset), .CLK_EN_I(1'b1),
    .CFG_REQ_I(cfg_req), .CFG_TCR_EN_I(cfg_tcr), .CFG_TCR_EXT_I(cfg_ext), .CFG_FGR_I(cfg_fgr),
    .CFG_WIDE_HOT_I(cfg_wide), .HIGH_RATE_I(high_rate), .CASE_TEMP_I(temp), .cmd(link.ctrl),
    .CFG_DONE_O(cfg_done), .REF_ISSUED_O(ref_issued));
  drrm_device u_drrm_device (.CORE_CLK_I(core_clk), .RESET_I(reset), .CLK_EN_I(1'b1),
    .CASE_TEMP_I(temp), .cmd(link.dev), .TCR_EN_O(tcr_en), .TCR_EXT_O(tcr_ext),
    .FGR_MODE_O(fgr_mode), .REFRESH_DO_O(ref_do), .REFRESH_SKIP_O(ref_skip),
    .REFRESH_RATE_O(ref_rate), .REFRESH_BUSY_O(ref_busy));
  drrm_properties u_drrm_properties (.CORE_CLK_I(core_clk), .RESET_I(reset),
    .cs_n(link.cs_n), .act_n(link.act_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .bg(link.bg), .mr_sel(link.mr_sel), .addr(link.addr),
    .TCR_EN_O(tcr_en), .TCR_EXT_O(tcr_ext), .FGR_MODE_O(fgr_mode), .REFRESH_DO_O(ref_do),
    .REFRESH_SKIP_O(ref_skip), .REFRESH_RATE_O(ref_rate), .REFRESH_BUSY_O(ref_busy));
  always #10 core_clk = ~core_clk;
  // Cycle count; the ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Program one mode, then watch eight refreshes; request held until done
  task automatic run_row(input drrm_row_s r);
    int n;
    int last;
    int skips;
    @(posedge core_clk);
    {cfg_tcr, cfg_ext, cfg_wide, high_rate} <= {r.temp_controlled_refresh, r.ext, r.wide, r.high};
    cfg_fgr <= r.fgr;
    temp <= r.temp;
    cfg_req <= 1'b1;
    n = 0;
    // Drop the request once the thermal write shows, before the run state samples it again
    while (!(link.cs_n === 1'b0 && link.we_n === 1'b0) && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    cfg_req <= 1'b0;
    #1;
    chk("cfg done", 16'h0001, 16'(cfg_done));
    n = 0;
    skips = 0;
    last = cyc;
    while (n < 8 && cyc < 90000) begin
      @(posedge core_clk);
      #1;
      if (ref_issued === 1'b1) begin
        chk("pins", 16'h0009, 16'({link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n}));
        if (r.fgr == 3'h5 || r.fgr == 3'h6) chk("bg0", 16'(r.high), 16'(link.bg[0]));
        if (n > 0) chk("gap", 16'h0001, 16'(cyc - last <= r.gap + 1 && cyc - last >= r.gap - 1));
        last = cyc;
        n++;
      end
      if (ref_skip === 1'b1) skips++;
      if (ref_do === 1'b1) chk("rate", 16'(r.rate), 16'(ref_rate));
    end
    chk("skips", 16'(r.skips), 16'(skips));
    chk("tcr", 16'(r.temp_controlled_refresh), 16'(tcr_en));
    chk("fgr", 16'(r.xfgr), 16'(fgr_mode));
  endtask
  // Main sequence: table first, then reset in mid-run
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("idle cs", 16'h0001, 16'(link.cs_n));
    @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("fgr rst", 16'h0000, 16'(fgr_mode));
    chk("tcr rst", 16'h0000, 16'(tcr_en));
    final_report();
  end
endmodule // tb_dram_refresh_rate_modes
